/* rtl/dcc_pkg.sv */
package dcc_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
   localparam logic [3:0] ADDR_FLAGS = 4'h1;
   localparam logic [3:0] ADDR_S1_VAL_LO = 4'h2;
   localparam logic [3:0] ADDR_S1_VAL_HI = 4'h3;
   localparam logic [3:0] ADDR_S2_VAL_LO = 4'h4;
   localparam logic [3:0] ADDR_S2_VAL_HI = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [7:0] MODE_CTRL_RST = 8'h00;
   localparam int S1_FIELD_LSB = 0;
   localparam int S2_FIELD_LSB = 4;
   localparam int S1_FLAG_BIT = 2;
   localparam int S2_FLAG_BIT = 3;

   // -----------------------------------------------------------------
   // Mode codes
   // -----------------------------------------------------------------
   localparam logic [3:0] M_CAP_FALL = 4'h4;
   localparam logic [3:0] M_CAP_RISE = 4'h5;
   localparam logic [3:0] M_CAP_4 = 4'h6;
   localparam logic [3:0] M_CAP_16 = 4'h7;
   localparam logic [3:0] M_CMP_SET = 4'h8;
   localparam logic [3:0] M_CMP_CLR = 4'h9;
   localparam logic [3:0] M_CMP_TGL = 4'hA;
   localparam logic [3:0] M_RESERVED = 4'hB;
   localparam logic [3:0] M_CMP_TRIG = 4'hF;
   localparam logic [3:0] PRE_4_LAST = 4'h3;
   localparam logic [3:0] PRE_16_LAST = 4'hF;

   typedef struct packed {
      logic [15:0] value;
      logic event_flag;
      logic pin_out;
      logic pin_drive;
      logic trigger;
   } dcc_set_out_t;

endpackage

/* rtl/dcc_set.sv */
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
module dcc_set (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_mode,
   input wire logic [15:0] i_timer1_count,
   input wire logic i_capture_input_pin,
   input wire logic i_wr_lo,
   input wire logic i_wr_hi,
   input wire logic [7:0] i_wdata,
   output dcc_pkg::dcc_set_out_t o_set
);

   logic [15:0] val_r, val_nxt;
   logic [3:0] pre_r, pre_nxt;
   logic pin_r, pin_nxt;
   logic pin_prev_r;
   logic off, cap_mode, reserved, rise, fall, cap_evt, match;
   logic clr_last_r, clr_last_nxt;
   dcc_pkg::dcc_set_out_t out_nxt;

   // -----------------------------------------------------------------
   // Event decode
   // -----------------------------------------------------------------
   always_comb begin
      off = (i_mode[3:2] == 2'b00); // R02
      reserved = (i_mode == dcc_pkg::M_RESERVED); // R14
      cap_mode = (i_mode[3:2] == 2'b01);
      rise = i_capture_input_pin & ~pin_prev_r;
      fall = ~i_capture_input_pin & pin_prev_r;
      match = i_mode[3] & ~reserved & (i_timer1_count == val_r);
      cap_evt = 1'b0;
      pre_nxt = pre_r;
      if (!cap_mode) begin
         pre_nxt = 4'h0; // R12
      end else begin
         case (i_mode)
            dcc_pkg::M_CAP_FALL: cap_evt = fall; // R03
            dcc_pkg::M_CAP_RISE: cap_evt = rise; // R03
            dcc_pkg::M_CAP_4: begin
               if (rise) begin
                  cap_evt = ((pre_r & dcc_pkg::PRE_4_LAST) == dcc_pkg::PRE_4_LAST); // R04
                  pre_nxt = pre_r + 4'h1;
               end
            end
            dcc_pkg::M_CAP_16: begin
               if (rise) begin
                  cap_evt = (pre_r == dcc_pkg::PRE_16_LAST); // R04
                  pre_nxt = pre_r + 4'h1;
               end
            end
            default: cap_evt = 1'b0;
         endcase
      end
      val_nxt = val_r;
      if (cap_evt) begin
         val_nxt = i_timer1_count; // R10
      end
      if (i_wr_lo) begin
         val_nxt[7:0] = i_wdata;
      end
      if (i_wr_hi) begin
         val_nxt[15:8] = i_wdata;
      end
      clr_last_nxt = clr_last_r;
      case (i_mode)
         dcc_pkg::M_CMP_SET: pin_nxt = match ? 1'b1 : pin_r; // R05
         dcc_pkg::M_CMP_CLR: pin_nxt = match ? 1'b0 : pin_r; // R05
         dcc_pkg::M_CMP_TGL: pin_nxt = match ? ~pin_r : pin_r; // R06
         default: pin_nxt = pin_r;
      endcase
      if (off || reserved) begin
         // Off default: clear-on-match mode idles high, the others low.
         pin_nxt = clr_last_r; // R13
      end else begin
         clr_last_nxt = (i_mode == dcc_pkg::M_CMP_CLR);
      end
      out_nxt.value = val_nxt;
      out_nxt.event_flag = cap_evt | match; // R05
      out_nxt.pin_out = pin_nxt;
      out_nxt.pin_drive = (i_mode == dcc_pkg::M_CMP_SET) || (i_mode == dcc_pkg::M_CMP_CLR)
         || (i_mode == dcc_pkg::M_CMP_TGL); // R07
      out_nxt.trigger = match && (i_mode == dcc_pkg::M_CMP_TRIG); // R08
   end

   // -----------------------------------------------------------------
   // State registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         val_r <= 16'h0000;
         pre_r <= 4'h0;
         pin_r <= 1'b0;
         pin_prev_r <= 1'b0;
         clr_last_r <= 1'b0;
         o_set <= '0;
      end else begin
         val_r <= val_nxt;
         pre_r <= pre_nxt;
         pin_prev_r <= i_capture_input_pin;
         clr_last_r <= clr_last_nxt;
         pin_r <= pin_nxt;
         o_set <= out_nxt;
      end
   end

endmodule

/* rtl/dcc_top.sv */
`timescale 1ns/100ps
// Function
// R01 - Upper nibble set 2, lower nibble set 1
// R02 - Mode 00xx turns set off, resets it
// R03 - Capture on falling (0100) or rising (0101)
// R04 - Capture every 4th (0110), 16th (0111) rise
// R05 - Match sets (1000) or clears (1001) output
// R06 - Match toggles output with code 1010
// R07 - Codes 11xx set flag, pin undriven
// R08 - Code 1111 flags and pulses conversion trigger
// R09 - Timer1 count never cleared by match
// R10 - Capture copies Timer1, flag set, overwrites
// R11 - Set 1 flag bit 2, set 2 bit 3
// R12 - Prescaler cleared when off, non-capture, reset
// R13 - Off output default 0, clear mode 1
// R14 - Code 1011 acts off; control resets zero
module dcc_top (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [15:0] i_timer1_count,
   input wire logic i_capture_input_pin,
   input wire logic i_adc_enable,
   output logic o_set1_compare_pin,
   output logic o_set1_compare_pin_oe_n,
   output logic o_set2_compare_pin,
   output logic o_set2_compare_pin_oe_n,
   output logic o_adc_start,
   output logic [7:0] o_peripheral_flag_register
);

   logic [7:0] dual_cc_mode_control_r, dual_cc_mode_control_nxt;
   logic [7:0] flags_r, flags_nxt;
   logic [7:0] rdata_nxt;
   dcc_pkg::dcc_set_out_t s1, s2;
   logic wr_mode, wr_flags;

   // -----------------------------------------------------------------
   // Register sets
   // -----------------------------------------------------------------
   dcc_set u_set1 (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_mode(dual_cc_mode_control_r[dcc_pkg::S1_FIELD_LSB +: 4]), // R01
      .i_timer1_count(i_timer1_count), // R09
      .i_capture_input_pin(i_capture_input_pin),
      .i_wr_lo(i_wr && i_addr == dcc_pkg::ADDR_S1_VAL_LO),
      .i_wr_hi(i_wr && i_addr == dcc_pkg::ADDR_S1_VAL_HI),
      .i_wdata(i_wdata),
      .o_set(s1)
   );

   dcc_set u_set2 (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_mode(dual_cc_mode_control_r[dcc_pkg::S2_FIELD_LSB +: 4]), // R01
      .i_timer1_count(i_timer1_count),
      .i_capture_input_pin(i_capture_input_pin),
      .i_wr_lo(i_wr && i_addr == dcc_pkg::ADDR_S2_VAL_LO),
      .i_wr_hi(i_wr && i_addr == dcc_pkg::ADDR_S2_VAL_HI),
      .i_wdata(i_wdata),
      .o_set(s2)
   );

   // -----------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------
   always_comb begin
      wr_mode = i_wr && (i_addr == dcc_pkg::ADDR_MODE_CTRL);
      wr_flags = i_wr && (i_addr == dcc_pkg::ADDR_FLAGS);
      dual_cc_mode_control_nxt = wr_mode ? i_wdata : dual_cc_mode_control_r;
      flags_nxt = wr_flags ? (flags_r & i_wdata) : flags_r;
      // Hardware set wins over a software clear in the same cycle.
      flags_nxt[dcc_pkg::S1_FLAG_BIT] = flags_nxt[dcc_pkg::S1_FLAG_BIT] | s1.event_flag; // R11
      flags_nxt[dcc_pkg::S2_FLAG_BIT] = flags_nxt[dcc_pkg::S2_FLAG_BIT] | s2.event_flag; // R11
      case (i_addr)
         dcc_pkg::ADDR_MODE_CTRL: rdata_nxt = dual_cc_mode_control_r;
         dcc_pkg::ADDR_FLAGS: rdata_nxt = flags_r;
         dcc_pkg::ADDR_S1_VAL_LO: rdata_nxt = s1.value[7:0];
         dcc_pkg::ADDR_S1_VAL_HI: rdata_nxt = s1.value[15:8];
         dcc_pkg::ADDR_S2_VAL_LO: rdata_nxt = s2.value[7:0];
         dcc_pkg::ADDR_S2_VAL_HI: rdata_nxt = s2.value[15:8];
         dcc_pkg::ADDR_STATUS: rdata_nxt = {4'h0, s2.pin_drive, s2.pin_out, s1.pin_drive, s1.pin_out};
         default: rdata_nxt = 8'h00;
      endcase
      if (!i_rd) begin
         rdata_nxt = 8'h00;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         dual_cc_mode_control_r <= dcc_pkg::MODE_CTRL_RST; // R14
         flags_r <= 8'h00;
         o_rdata <= 8'h00;
         o_set1_compare_pin <= 1'b0;
         o_set1_compare_pin_oe_n <= 1'b1;
         o_set2_compare_pin <= 1'b0;
         o_set2_compare_pin_oe_n <= 1'b1;
         o_adc_start <= 1'b0;
         o_peripheral_flag_register <= 8'h00;
      end else begin
         dual_cc_mode_control_r <= dual_cc_mode_control_nxt;
         flags_r <= flags_nxt;
         o_rdata <= rdata_nxt;
         o_set1_compare_pin <= s1.pin_out;
         o_set1_compare_pin_oe_n <= ~s1.pin_drive; // R07
         o_set2_compare_pin <= s2.pin_out;
         o_set2_compare_pin_oe_n <= ~s2.pin_drive; // R07
         o_adc_start <= (s1.trigger | s2.trigger) & i_adc_enable; // R08
         o_peripheral_flag_register <= flags_nxt;
      end
   end

endmodule

/* tb/dcc_top_chk.sv */
`timescale 1ns/100ps
// ----
// Port checks
// ----
module dcc_top_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic o_set1_compare_pin,
   input wire logic o_set1_compare_pin_oe_n,
   input wire logic o_adc_start,
   input wire logic [7:0] o_peripheral_flag_register
);
   logic [7:0] m_r, m1_r, m2_r, m3_r;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         {m_r, m1_r, m2_r, m3_r} <= '0;
      end else begin
         m_r <= (i_wr && i_addr == 4'h0) ? i_wdata : m_r;
         {m1_r, m2_r, m3_r} <= {m_r, m1_r, m2_r};
      end
   end
   function automatic logic drv(input logic [3:0] m);
      return m == 4'h8 || m == 4'h9 || m == 4'hA;
   endfunction
   function automatic logic act(input logic [3:0] m);
      return m[3:2] != 2'b00 && m != 4'hB;
   endfunction
   sequence rd_ctrl;
      i_rd && i_addr == 4'h0;
   endsequence
   a_ctrl_readback: assert property (rd_ctrl |=> o_rdata == $past(m_r))
      else $error("control readback wrong");
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not idle");
   a_flag_bits: assert property ((o_peripheral_flag_register & 8'hF3) == 8'h00)
      else $error("flag outside bits 2 and 3");
   a_oe_cause: assert property (!o_set1_compare_pin_oe_n |->
      drv(m1_r[3:0]) || drv(m2_r[3:0]) || drv(m3_r[3:0])) else $error("pin driven in wrong mode");
   a_flag_cause: assert property ($rose(o_peripheral_flag_register[2]) |->
      act(m1_r[3:0]) || act(m2_r[3:0]) || act(m3_r[3:0])) else $error("flag set while off");
   a_adc_cause: assert property (o_adc_start |->
      m1_r[3:0] == 4'hF || m2_r[3:0] == 4'hF || m3_r[3:0] == 4'hF) else $error("trigger in wrong mode");
   a_set_holds: assert property ({m1_r[3:0], m2_r[3:0], m3_r[3:0]} == 12'h888 |->
      !$fell(o_set1_compare_pin)) else $error("pin fell in set mode");
   a_clr_holds: assert property ({m1_r[3:0], m2_r[3:0], m3_r[3:0]} == 12'h999 |->
      !$rose(o_set1_compare_pin)) else $error("pin rose in clear mode");
endmodule

/* tb/dcc_pin_model.sv */
`timescale 1ns/100ps
// ----
// Capture source
// ----
module dcc_pin_model (
   input wire logic i_clk,
   output logic o_cap
);
   initial o_cap = 1'b0;
   task pulse(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_cap <= 1'b1;
         repeat (2) @(posedge i_clk);
         o_cap <= 1'b0;
         repeat (2) @(posedge i_clk);
      end
      repeat (3) @(posedge i_clk);
   endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
// ----
// Bench
// ----
module testbench;
   logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, aen = 1, p1, p1n, p2, p2n, adc, cap;
   logic [3:0] ad = 4'h0;
   logic [7:0] wd = 8'h00, rdat, fl;
   logic [15:0] tmr = 16'h0000, v = 16'h002A;
   logic [15:0] q[$];
   int failures = 0, tests_run = 0, cyc = 0, adc_n = 0;
   dcc_top uut (.i_core_clk(clk), .i_rst(rst), .i_addr(ad), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
      .i_timer1_count(tmr), .i_capture_input_pin(cap), .i_adc_enable(aen), .o_set1_compare_pin(p1),
      .o_set1_compare_pin_oe_n(p1n), .o_set2_compare_pin(p2), .o_set2_compare_pin_oe_n(p2n), .o_adc_start(adc),
      .o_peripheral_flag_register(fl));
   dcc_pin_model pm (.i_clk(clk), .o_cap(cap));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task results();
      if (failures == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      ad <= a;
      rd <= 1'b1;
      q.push_back({8'h00, e});
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // Presents a one-cycle compare match, then lets the outputs settle.
   task hit(input logic [15:0] t);
      @(posedge clk);
      tmr <= t;
      @(posedge clk);
      tmr <= t + 16'h0100;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      rd_d <= rd;
      cyc <= cyc + 1;
   end
   always @(negedge clk) begin
      if (adc === 1'b1) adc_n++;
      if (rd_d) chk({8'h00, rdat}, q.pop_front());
      if (cyc > 20000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_reg(4'h0, 8'h00);
      chk({p2n, p2}, 16'h0002);
      wr_reg(4'hF, 8'hFF);
      rd_reg(4'hF, 8'h00);
      v = lfsr(v);
      tmr <= v + 16'h0100;
      wr_reg(4'h2, v[7:0]);
      wr_reg(4'h3, v[15:8]);
      wr_reg(4'h0, 8'h08);
      hit(v);
      chk({p1n, p1}, 16'h0001);
      rd_reg(4'h6, 8'h03);
      rd_reg(4'h1, 8'h04);
      wr_reg(4'h1, 8'h00);
      wr_reg(4'h0, 8'h09);
      hit(v);
      chk({p1n, p1}, 16'h0000);
      wr_reg(4'h0, 8'h00);
      hit(v);
      chk({p1n, p1}, 16'h0003);
      wr_reg(4'h0, 8'h0A);
      hit(v);
      chk({p1n, p1}, 16'h0000);
      wr_reg(4'h1, 8'h00);
      wr_reg(4'h0, 8'h0B);
      hit(v);
      chk({p1n, p1}, 16'h0002);
      rd_reg(4'h1, 8'h00);
      for (int c = 12; c < 16; c++) begin
         wr_reg(4'h1, 8'h00);
         wr_reg(4'h0, 8'(c));
         hit(v);
         chk(p1n, 16'h0001);
         rd_reg(4'h1, 8'h04);
      end
      chk(adc_n, 16'h0001);
      @(posedge clk);
      aen <= 1'b0;
      hit(v);
      chk(adc_n, 16'h0001);
      for (int k = 0; k < 2; k++) begin
         wr_reg(4'h0, k ? 8'h40 : 8'h50);
         wr_reg(4'h1, 8'h00);
         v = lfsr(v);
         tmr <= v;
         pm.pulse(1);
         rd_reg(4'h4, v[7:0]);
         rd_reg(4'h5, v[15:8]);
         rd_reg(4'h1, 8'h08);
      end
      for (int k = 0; k < 2; k++) begin
         wr_reg(4'h0, 8'h00);
         wr_reg(4'h0, k ? 8'h70 : 8'h60);
         wr_reg(4'h1, 8'h00);
         pm.pulse(k ? 15 : 3);
         rd_reg(4'h1, 8'h00);
         pm.pulse(1);
         rd_reg(4'h1, 8'h08);
      end
      results();
   end
endmodule
bind dcc_top dcc_top_chk chk_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_set1_compare_pin(o_set1_compare_pin),
   .o_set1_compare_pin_oe_n(o_set1_compare_pin_oe_n), .o_adc_start(o_adc_start),
   .o_peripheral_flag_register(o_peripheral_flag_register));
